// ### rtl/sar_defs.svh
// constants for the converter control and serial port
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH

// core clock
`define SAR_CLK_PERIOD_NS 10
// longest conversion time, rounded down to whole cycles
`define SAR_CONV_TIME_NS 550
`define SAR_CONV_CYCLES ((`SAR_CONV_TIME_NS) / (`SAR_CLK_PERIOD_NS))
// initialisation wait after power-up, reset or power-down exit
`define SAR_INIT_TIME_MS 10
`define SAR_INIT_CYCLES (((`SAR_INIT_TIME_MS) * 1000000) / (`SAR_CLK_PERIOD_NS))
// internal timer that ends a global reset
`define SAR_GRST_TIME_NS 200
`define SAR_GRST_CYCLES ((`SAR_GRST_TIME_NS) / (`SAR_CLK_PERIOD_NS))

// control word fields
`define SAR_CW_VALID 7
`define SAR_CW_RSVD 6
`define SAR_CW_CH_HI 5
`define SAR_CW_CH_LO 3
`define SAR_CW_RG_HI 2
`define SAR_CW_RG_LO 0
`define SAR_CW_BITS 8

// result packet fields
`define SAR_PKT_BITS 24
`define SAR_PKT_RES_HI 23
`define SAR_PKT_RES_LO 6
`define SAR_PKT_CH_HI 5
`define SAR_PKT_CH_LO 3
`define SAR_PKT_RG_HI 2
`define SAR_PKT_RG_LO 0
`define SAR_PKT_LAST 5'h17

// sequencer
`define SAR_SEQ_DEPTH 16
`define SAR_SEQ_DEF_LAST 4'h7
`define SAR_SEQ_DEF_RANGE 3'h7

`endif

// ### rtl/sar_pkg.sv
// types shared by the converter control and its serial port
package sar_pkg;

	typedef logic [2:0] sar_chan_t;
	typedef logic [2:0] sar_range_t;
	typedef logic [17:0] sar_result_t;
	typedef logic [23:0] sar_packet_t;
	typedef logic [7:0] sar_word_t;

	typedef enum logic [2:0] {
		SAR_INIT,
		SAR_IDLE,
		SAR_CONVERT,
		SAR_DOWN,
		SAR_GRESET
	} sar_state_t;

endpackage

// ### rtl/sar_link.sv
// serial port logic clocked by the host serial clock
`timescale 1ns/100ps
`default_nettype none
`include "sar_defs.svh"

module sar_link (
	// link clock and hold-off from the core
	input wire logic serial_clock_in,
	input wire logic link_rst_n,
	// link-domain pins, set up to the serial clock edge
	input wire logic chip_select_n,
	input wire logic serial_control_in,
	// packet held stable by the core while the window is open
	input wire sar_pkg::sar_packet_t packet,
	// to pins
	output logic serial_result_out,
	output logic echo,
	// received control words
	output sar_pkg::sar_word_t word,
	output logic word_toggle
);
	import sar_pkg::*;

	logic [4:0] bit_idx;
	logic [2:0] in_cnt;
	logic [6:0] in_shift;

	// held in reset during each conversion, so every window starts at the msb
	// no core-clock logic on this path, so full link rate is kept
	always_ff @(posedge serial_clock_in or negedge link_rst_n) begin // see R22
		if (!link_rst_n) begin
			bit_idx <= 5'h00;
		end else if (!chip_select_n) begin
			if (bit_idx == `SAR_PKT_LAST) begin // see R20
				bit_idx <= 5'h00;
			end else begin
				bit_idx <= bit_idx + 5'h01; // see R17
			end
		end
	end

	// echo starts low each window and runs at half the input clock
	always_ff @(posedge serial_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			echo <= 1'b0; // see R16
		end else if (!chip_select_n) begin
			echo <= ~echo; // see R17
		end
	end

	// data is a mux of stable flops so the msb shows before the first edge
	assign serial_result_out = packet[5'(`SAR_PKT_LAST - bit_idx)]; // see R20

	// word assembly; a partial word dies with the window
	always_ff @(posedge serial_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			in_cnt <= 3'h0; // see R26
			in_shift <= 7'h00;
			word <= 8'h00;
			word_toggle <= 1'b0;
		end else if (!chip_select_n) begin
			in_cnt <= in_cnt + 3'h1; // see R18
			in_shift <= {in_shift[5:0], serial_control_in};
			if (in_cnt == 3'h7) begin
				word <= {in_shift, serial_control_in};
				word_toggle <= ~word_toggle;
			end
		end
	end

endmodule // sar_link

`default_nettype wire

// ### rtl/sar_ctrl.sv
// conversion control, sequencer and serial port of the converter
// What this block and its host do
// R01: host waits 10ms after power-on reset
// R02: convert rising edge samples and starts conversion
// R03: conversion runs to end unless global reset
// R04: busy high from start until conversion completes
// R05: host returns convert low 40-60ns or later
// R06: conversion ends within 550ns; 1Msps throughput
// R07: convert held high between conversions means nap
// R08: host holds convert low 420ns to leave nap
// R09: power-down ignores requests, waits conversion end
// R10: two power-down rises without conversion reset all
// R11: reset clears output and restores default sequence
// R12: reset during conversion stops it at once
// R13: window opens after init and at busy fall
// R14: host ends transaction 20ns before next start
// R15: control words only accepted inside the window
// R16: before busy falls, echo low, result loaded
// R17: each serial rising edge shifts and toggles echo
// R18: control bits latched on serial rising edges
// R19: chip select high disables port, outputs released
// R20: packet 24 bits msb first, repeats past 24
// R21: host captures on serial rising edges or echo
// R22: serial clock up to 100MHz accepted
// R23: word: valid bit7, zero bit6, channel, range
// R24: valid words replace sequencer, up to sixteen
// R25: no valid word advances pointer with wrap
// R26: partial words dropped, bit count restarts per window
`timescale 1ns/100ps
`default_nettype none
`include "sar_defs.svh"

module sar_ctrl #(
	parameter int unsigned INIT_CYCLES = `SAR_INIT_CYCLES
) (
	// core clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// conversion pins
	input wire logic convert_start_pin,
	input wire logic power_down_pin,
	output logic busy,
	// analog core
	input wire sar_pkg::sar_result_t conv_result,
	output logic hold_sample,
	output logic nap,
	output logic powered_down,
	output sar_pkg::sar_chan_t mux_channel,
	output sar_pkg::sar_range_t input_range,
	// serial link
	input wire logic serial_clock_in,
	input wire logic chip_select_n,
	input wire logic serial_control_in,
	output logic serial_result_out,
	output logic serial_result_oe_n,
	output logic serial_clock_echo,
	output logic serial_clock_echo_oe_n
);
	import sar_pkg::*;

	localparam int unsigned CONV_CYCLES = `SAR_CONV_CYCLES;
	localparam int unsigned GRST_CYCLES = `SAR_GRST_CYCLES;
	localparam int unsigned DEPTH = `SAR_SEQ_DEPTH;

	sar_state_t state;
	logic [19:0] timer;
	logic window;
	logic link_rst_n;
	sar_packet_t packet;
	logic echo;
	sar_word_t word;
	logic word_toggle;

	// pin synchronisers
	logic cnv_s1, cnv_s2, cnv_s3;
	logic pd_s1, pd_s2, pd_s3;
	logic cs_s1, cs_s2;
	logic wt_s1, wt_s2, wt_s3;
	logic cnv_rise, pd_rise, word_new;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnv_s1 <= 1'b0;
			cnv_s2 <= 1'b0;
			cnv_s3 <= 1'b0;
			pd_s1 <= 1'b0;
			pd_s2 <= 1'b0;
			pd_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			wt_s1 <= 1'b0;
			wt_s2 <= 1'b0;
			wt_s3 <= 1'b0;
		end else begin
			cnv_s1 <= convert_start_pin;
			cnv_s2 <= cnv_s1;
			cnv_s3 <= cnv_s2;
			pd_s1 <= power_down_pin;
			pd_s2 <= pd_s1;
			pd_s3 <= pd_s2;
			cs_s1 <= chip_select_n;
			cs_s2 <= cs_s1;
			wt_s1 <= word_toggle;
			wt_s2 <= wt_s1;
			wt_s3 <= wt_s2;
		end
	end

	assign cnv_rise = cnv_s2 & ~cnv_s3; // see R02
	assign pd_rise = pd_s2 & ~pd_s3;
	assign word_new = wt_s2 ^ wt_s3;

	// power-down rises since the last conversion
	logic pd_armed;
	logic grst_go;
	logic conv_start;

	assign grst_go = pd_rise & pd_armed; // see R10
	assign conv_start = (state == SAR_IDLE) & cnv_rise & ~pd_s2; // see R09

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_armed <= 1'b0;
		end else if (grst_go || conv_start) begin
			pd_armed <= 1'b0;
		end else if (pd_rise) begin
			pd_armed <= 1'b1;
		end
	end

	// main sequence of the converter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= SAR_INIT;
			timer <= 20'h00000;
		end else if (grst_go) begin
			state <= SAR_GRESET; // see R12
			timer <= 20'h00000;
		end else begin
			case (state)
				SAR_INIT: begin
					if (pd_s2) begin
						state <= SAR_DOWN;
						timer <= 20'h00000;
					end else if (timer == 20'(INIT_CYCLES - 1)) begin
						state <= SAR_IDLE; // see R13
						timer <= 20'h00000;
					end else begin
						timer <= timer + 20'h00001;
					end
				end
				SAR_IDLE: begin
					if (pd_s2) begin
						state <= SAR_DOWN; // see R09
					end else if (conv_start) begin
						state <= SAR_CONVERT;
						timer <= 20'h00000;
					end
				end
				SAR_CONVERT: begin
					// only the global reset above leaves early
					if (timer == 20'(CONV_CYCLES - 1)) begin // see R06
						state <= pd_s2 ? SAR_DOWN : SAR_IDLE; // see R03
						timer <= 20'h00000;
					end else begin
						timer <= timer + 20'h00001;
					end
				end
				SAR_DOWN: begin
					if (!pd_s2) begin
						state <= SAR_INIT;
						timer <= 20'h00000;
					end
				end
				SAR_GRESET: begin
					if (timer == 20'(GRST_CYCLES - 1)) begin // see R10
						state <= pd_s2 ? SAR_DOWN : SAR_INIT;
						timer <= 20'h00000;
					end else begin
						timer <= timer + 20'h00001;
					end
				end
				default: begin
					state <= SAR_INIT;
					timer <= 20'h00000;
				end
			endcase
		end
	end

	logic conv_last;
	assign conv_last = (state == SAR_CONVERT) && (timer == 20'(CONV_CYCLES - 1));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
		end else if (grst_go) begin
			busy <= 1'b0;
		end else if (conv_start) begin
			busy <= 1'b1; // see R04
		end else if (conv_last) begin
			busy <= 1'b0;
		end
	end

	// window and link hold-off open at busy fall or init end, close at conversion start or global reset; the link has no edges to reset by
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			window <= 1'b0;
			link_rst_n <= 1'b0;
		end else if (grst_go || conv_start) begin
			window <= 1'b0; // see R15
			link_rst_n <= 1'b0; // see R26
		end else if ((state == SAR_INIT && timer == 20'(INIT_CYCLES - 1)) || conv_last) begin
			window <= 1'b1; // see R13
			link_rst_n <= 1'b1;
		end
	end

	// result packet, loaded while the link is still held
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			packet <= 24'h000000;
		end else if (grst_go) begin
			packet <= 24'h000000; // see R11
		end else if (conv_last) begin
			packet <= {conv_result, mux_channel, input_range}; // see R16
		end
	end

	// sequencer and words collected in the current window
	logic [5:0] seq [DEPTH];
	logic [5:0] pend [DEPTH];
	logic [3:0] seq_last;
	logic [3:0] ptr;
	logic [4:0] pend_cnt;
	logic [3:0] next_ptr;
	logic take_word;
	logic commit;

	// reserved bit is not checked, only the valid flag
	assign take_word = word_new & window & word[`SAR_CW_VALID] & (pend_cnt != 5'h10); // see R23
	assign commit = conv_start & (pend_cnt != 5'h00);
	assign next_ptr = (ptr == seq_last) ? 4'h0 : ptr + 4'h1; // see R25

	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_seq
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					seq[i] <= {3'(i), `SAR_SEQ_DEF_RANGE};
					pend[i] <= 6'h00;
				end else if (grst_go) begin
					seq[i] <= {3'(i), `SAR_SEQ_DEF_RANGE}; // see R11
					pend[i] <= 6'h00;
				end else begin
					if (commit) begin
						seq[i] <= pend[i]; // see R24
					end
					if (take_word && pend_cnt == 5'(i)) begin
						pend[i] <= word[`SAR_CW_CH_HI:`SAR_CW_RG_LO]; // see R15
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_last <= `SAR_SEQ_DEF_LAST;
			ptr <= `SAR_SEQ_DEF_LAST;
			pend_cnt <= 5'h00;
		end else if (grst_go) begin
			seq_last <= `SAR_SEQ_DEF_LAST;
			ptr <= `SAR_SEQ_DEF_LAST;
			pend_cnt <= 5'h00;
		end else if (conv_start) begin
			pend_cnt <= 5'h00;
			if (commit) begin
				seq_last <= 4'(pend_cnt - 5'h01); // see R24
				ptr <= 4'h0;
			end else begin
				ptr <= next_ptr; // see R25
			end
		end else if (take_word) begin
			pend_cnt <= pend_cnt + 5'h01; // see R24
		end
	end

	// configuration applied to the conversion being started
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mux_channel <= 3'h0;
			input_range <= `SAR_SEQ_DEF_RANGE;
		end else if (grst_go) begin
			mux_channel <= 3'h0;
			input_range <= `SAR_SEQ_DEF_RANGE;
		end else if (commit) begin
			mux_channel <= pend[0][5:3];
			input_range <= pend[0][2:0];
		end else if (conv_start) begin
			mux_channel <= seq[next_ptr][5:3];
			input_range <= seq[next_ptr][2:0];
		end
	end

	// analog controls
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_sample <= 1'b0;
			nap <= 1'b0;
			powered_down <= 1'b0;
		end else begin
			hold_sample <= (state == SAR_CONVERT) | conv_start; // see R02
			nap <= (state == SAR_IDLE) & cnv_s2 & ~conv_start; // see R07
			powered_down <= (state == SAR_DOWN); // see R09
		end
	end

	// output enables follow chip select; lags it by the synchroniser
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			serial_result_oe_n <= 1'b1;
			serial_clock_echo_oe_n <= 1'b1;
		end else begin
			serial_result_oe_n <= cs_s2; // see R19
			serial_clock_echo_oe_n <= cs_s2;
		end
	end

	assign serial_clock_echo = echo;

	sar_link u_link (
		.serial_clock_in(serial_clock_in),
		.link_rst_n(link_rst_n),
		.chip_select_n(chip_select_n),
		.serial_control_in(serial_control_in),
		.packet(packet),
		.serial_result_out(serial_result_out),
		.echo(echo),
		.word(word),
		.word_toggle(word_toggle)
	);

endmodule // sar_ctrl

`default_nettype wire

// ### testbench/sar_ctrl_properties.sv
// assertions on the converter control ports
`timescale 1ns/100ps
`default_nettype none
module sar_ctrl_props (
	// core
	input wire logic clk,
	input wire logic arst_n,
	input wire logic convert_start_pin,
	input wire logic power_down_pin,
	input wire logic busy,
	input wire logic nap,
	input wire logic powered_down,
	input wire sar_pkg::sar_chan_t mux_channel,
	input wire sar_pkg::sar_range_t input_range,
	// link
	input wire logic chip_select_n,
	input wire logic serial_result_oe_n,
	input wire logic serial_clock_echo,
	input wire logic serial_clock_echo_oe_n
);
	logic [7:0] cnt;
	// counts busy cycles; too short a span would pass a plain rose/fell check
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) cnt <= 8'h00;
		else cnt <= busy ? cnt + 8'h01 : 8'h00;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_start;
		!busy ##1 busy;
	endsequence
	a_start_on_edge: assert property (s_start |-> $past(convert_start_pin, 2))
		else $error("busy rose without a convert edge");
	a_conv_full_len: assert property ($fell(busy) && !power_down_pin |-> cnt == 8'h37)
		else $error("conversion span wrong");
	a_conv_limit: assert property (busy |-> cnt < 8'h37)
		else $error("conversion too long");
	a_down_no_busy: assert property (powered_down |-> !busy)
		else $error("busy while powered down");
	a_nap_pin_high: assert property (nap |-> !busy && $past(convert_start_pin, 3))
		else $error("nap without convert held high");
	a_echo_low_busy: assert property (busy |-> !serial_clock_echo)
		else $error("echo not low during conversion");
	a_oe_follow_cs: assert property (chip_select_n [*4] |-> serial_result_oe_n)
		else $error("output enabled with chip select high");
	a_oe_pair_same: assert property (serial_clock_echo_oe_n == serial_result_oe_n)
		else $error("output enables differ");
	a_cfg_hold: assert property (busy && $past(busy) |-> $stable({mux_channel, input_range}))
		else $error("configuration changed mid conversion");
endmodule // sar_ctrl_props
bind sar_ctrl sar_ctrl_props i_props (.clk(clk), .arst_n(arst_n),
	.convert_start_pin(convert_start_pin), .power_down_pin(power_down_pin), .busy(busy),
	.nap(nap), .powered_down(powered_down), .mux_channel(mux_channel),
	.input_range(input_range), .chip_select_n(chip_select_n),
	.serial_result_oe_n(serial_result_oe_n), .serial_clock_echo(serial_clock_echo),
	.serial_clock_echo_oe_n(serial_clock_echo_oe_n));
`default_nettype wire

// ### testbench/sar_host_model.sv
// host serial controller model driving the link pins
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
	// link pins
	output logic serial_clock_in,
	output logic chip_select_n,
	output logic serial_control_in,
	input wire logic serial_result_out
);
	initial begin
		serial_clock_in = 1'b0;
		chip_select_n = 1'b1;
		serial_control_in = 1'b0;
	end
	// clock stands still outside frames; released data line is inverted
	task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
		rx = '0;
		chip_select_n = 1'b0;
		#30;
		for (int k = 0; k < n; k++) begin
			serial_control_in = tx[47 - k];
			#24; // 48ns period, below the top rate
			rx = {rx[46:0], serial_result_out};
			serial_clock_in = 1'b1;
			#24;
			serial_clock_in = 1'b0;
		end
		#10;
		chip_select_n = 1'b1;
		serial_control_in = ~serial_control_in;
		#20; // quiet gap before any convert edge
	endtask
endmodule // sar_host_model
`default_nettype wire

// ### testbench/sar_ctrl_bench.sv
// self-checking bench for the converter control
`timescale 1ns/100ps
`default_nettype none
module sar_ctrl_bench;
	import sar_pkg::*;
	localparam int unsigned INIT = 50;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic convert_start_pin = 1'b0;
	logic power_down_pin = 1'b0;
	sar_result_t conv_result = 18'h2A5C3;
	logic busy, hold_sample, nap, powered_down;
	sar_chan_t mux_channel;
	sar_range_t input_range;
	logic serial_clock_in, chip_select_n, serial_control_in, serial_result_out;
	logic serial_result_oe_n, serial_clock_echo, serial_clock_echo_oe_n;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	logic [47:0] rx;
	always #5 clk = ~clk;
	sar_ctrl #(.INIT_CYCLES(INIT)) i_dut (.clk(clk), .arst_n(arst_n),
		.convert_start_pin(convert_start_pin), .power_down_pin(power_down_pin), .busy(busy),
		.conv_result(conv_result), .hold_sample(hold_sample), .nap(nap),
		.powered_down(powered_down), .mux_channel(mux_channel), .input_range(input_range),
		.serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n),
		.serial_control_in(serial_control_in), .serial_result_out(serial_result_out),
		.serial_result_oe_n(serial_result_oe_n), .serial_clock_echo(serial_clock_echo),
		.serial_clock_echo_oe_n(serial_clock_echo_oe_n));
	// a released data line reads inverted, so a late enable shows up as bad data
	sar_host_model i_host (.serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n),
		.serial_control_in(serial_control_in),
		.serial_result_out(serial_result_oe_n ? ~serial_result_out : serial_result_out));
	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (err_total == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// whole run needs well under this
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (busy !== v && n < 100) begin
			@(posedge clk);
			n++;
		end
		#1;
		check("busy", busy, v);
	endtask
	// one conversion; hold keeps the pin high past busy to nap
	task automatic convert(input logic [2:0] ch, input logic [2:0] rg, input bit hold);
		@(posedge clk);
		#1 convert_start_pin = 1'b1;
		wait_busy(1'b1);
		check("channel", mux_channel, ch);
		check("range", input_range, rg);
		check("hold", hold_sample, 1'b1);
		@(posedge clk);
		#1 if (!hold) convert_start_pin = 1'b0;
		wait_busy(1'b0);
		repeat (10) @(posedge clk);
		if (hold) check("nap", nap, 1'b1);
		#1 convert_start_pin = 1'b0;
		repeat (43) @(posedge clk); // acquisition time
	endtask
	task automatic t_default();
		for (int k = 0; k < 9; k++) begin
			conv_result = 18'h2A5C3 + 18'(k);
			convert(3'(k), 3'h7, k == 3);
			i_host.xfer(48'h0, 24, rx);
			check("packet", rx[23:0], {conv_result, 3'(k), 3'h7});
		end
	endtask
	// flag-clear word and trailing partial word must be dropped
	task automatic t_program();
		i_host.xfer({8'hAA, 8'h3F, 8'h9C, 5'h1F, 19'h0}, 29, rx);
		check("packet", rx[28:5], {conv_result, 3'h0, 3'h7});
		check("echo", serial_clock_echo, 1'b1);
		repeat (10) @(posedge clk);
		convert(3'h5, 3'h2, 0);
		convert(3'h3, 3'h4, 0);
		convert(3'h5, 3'h2, 0);
		i_host.xfer(48'h0, 48, rx);
		check("first", rx[47:24], {conv_result, 3'h5, 3'h2});
		check("repeat", rx[23:0], {conv_result, 3'h5, 3'h2});
	endtask
	// a pulse before a conversion only arms; a double pulse inside one cuts it
	task automatic t_down();
		@(posedge clk);
		#1 power_down_pin = 1'b1;
		repeat (10) @(posedge clk);
		check("down", powered_down, 1'b1);
		#1 convert_start_pin = 1'b1;
		repeat (10) @(posedge clk);
		check("refused", busy, 1'b0);
		#1 convert_start_pin = 1'b0;
		power_down_pin = 1'b0;
		repeat (INIT + 10) @(posedge clk);
		#1 convert_start_pin = 1'b1;
		wait_busy(1'b1);
		@(posedge clk);
		#1 convert_start_pin = 1'b0;
		power_down_pin = 1'b1;
		repeat (6) @(posedge clk);
		#1 power_down_pin = 1'b0;
		repeat (6) @(posedge clk);
		check("armed_only", busy, 1'b1);
		#1 power_down_pin = 1'b1;
		repeat (6) @(posedge clk);
		check("aborted", busy, 1'b0);
		#1 power_down_pin = 1'b0;
		repeat (INIT + 40) @(posedge clk);
		i_host.xfer(48'h0, 24, rx);
		check("cleared", rx[23:0], 24'h0);
		convert(3'h0, 3'h7, 0);
		convert(3'h1, 3'h7, 0);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		check("rst_range", input_range, 3'h7);
		#1 arst_n = 1'b1;
		repeat (INIT + 10) @(posedge clk);
		check("oe_idle", serial_result_oe_n, 1'b1);
		t_default();
		t_program();
		t_down();
		print_verdict();
	end
endmodule // sar_ctrl_bench
`default_nettype wire
